/* hdl/dodi_pkg.sv */
// Constants for the digital output process-image block with diagnostics.
// Assumes one 100 MHz APB clock; all sizes are 8-bit process-image bytes.
package dodi_pkg;
  localparam int          IMG_W        = 8;
  localparam int          ADDR_W       = 12;
  // Register byte offsets
  localparam logic [11:0] OFF_OUT_IMG  = 12'h000;
  localparam logic [11:0] OFF_IN_IMG   = 12'h004;
  localparam logic [11:0] OFF_IRQ_STAT = 12'h008;
  localparam logic [11:0] OFF_IRQ_MASK = 12'h00C;
  // Reset values
  localparam logic [7:0]  RST_OUT_IMG  = 8'h00;
  localparam logic [7:0]  RST_IRQ_MASK = 8'h00;
  // Diagnostic variants
  localparam int          DIAG_NONE    = 0;
  localparam int          DIAG_FLAG    = 1;
  localparam int          DIAG_CODE    = 2;
  // Two-bit diagnostic codes
  localparam logic [1:0]  CODE_OK      = 2'h0;
  localparam logic [1:0]  CODE_OVL     = 2'h1;
  localparam logic [1:0]  CODE_SHORT   = 2'h2;
  localparam logic [1:0]  CODE_OPEN    = 2'h3;
  // Bus answer: access phase cycles before pready
  localparam int          WAIT_CYC     = 1;

  typedef enum logic [0:0] {
    DODI_IDLE = 1'b0,
    DODI_ACK  = 1'b1
  } dodi_apb_e;

  typedef struct packed {
    dodi_apb_e   st;
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
    logic [7:0]  out_img;
    logic [7:0]  flag;
    logic [7:0]  in_img;
    logic [7:0]  stat;
    logic [7:0]  mask;
    logic        irq;
  } dodi_state_s;
endpackage

/* hdl/dodi_top.sv */
// Digital output module process image: output control byte, diagnostic
// input byte, sticky fault status with mask and one level interrupt.
// Assumes APB master on pclk and fault inputs synchronous to pclk.
`timescale 1ns/1ps

// Function
// - Diagnostic variants keep one fault flag per output channel, set on any fault.
// - Diagnostics go out in the input image; control comes in via output image.
// - Two-channel flag variant: input bits 0,1 flag channels 1,2; outputs likewise.
// - Two-bit variant: input bits 1:0 code channel 1, bits 3:2 channel 2.
// - Two-channel two-bit variant shows four diagnostic bits; output bits 2 to 7 unused.
// - Four-channel modules: output bits 0 to 3 drive channels 1 to 4.
// - Four-channel flag variant: input bits 0 to 3 flag channels 1 to 4.
// - A single-bit flag reads 0 with no error and 1 on any fault.
// - Eight-channel modules: output bits 0 to 7 drive channels 1 to 8.
module dodi_top #(
  parameter int CHANNELS  = 2,
  parameter int DIAG_MODE = 1
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [dodi_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire logic [dodi_pkg::IMG_W-1:0]  fault_ovl,
  input  wire logic [dodi_pkg::IMG_W-1:0]  fault_short,
  input  wire logic [dodi_pkg::IMG_W-1:0]  fault_open,
  output logic      [dodi_pkg::IMG_W-1:0]  do_out,
  output logic      [dodi_pkg::IMG_W-1:0]  in_image,
  output logic                             irq
);
  import dodi_pkg::*;

  dodi_state_s s_r;
  dodi_state_s s_nxt;

  function automatic logic [7:0] chan_mask(input int n);
    logic [7:0] m;
    m = 8'h00;
    for (int i = 0; i < 8; i++)
    begin
      if (i < n)
        m[i] = 1'b1;
    end
    return m;
  endfunction

  // Short outranks overload, which outranks broken wire
  function automatic logic [1:0] diag_code(input logic ovl, input logic sc, input logic op);
    if (sc)
      return CODE_SHORT;
    else if (ovl)
      return CODE_OVL;
    else if (op)
      return CODE_OPEN;
    else
      return CODE_OK;
  endfunction

  function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
    case (a)
      OFF_OUT_IMG:  return 3'h1;
      OFF_IN_IMG:   return 3'h2;
      OFF_IRQ_STAT: return 3'h3;
      OFF_IRQ_MASK: return 3'h4;
      default:      return 3'h0;
    endcase
  endfunction

  // Two-bit codes fit four channels in one byte
  localparam int         CODE_CH = (CHANNELS > 4) ? 4 : CHANNELS;
  localparam logic [7:0] CMASK   = chan_mask(CHANNELS);
  localparam logic [7:0] FMASK   = (DIAG_MODE == DIAG_NONE) ? 8'h00 : CMASK;

  logic [7:0] raw_fault;
  logic [7:0] code_img;
  logic [7:0] img_nxt;
  logic [2:0] sel;

  assign raw_fault = (fault_ovl | fault_short | fault_open) & FMASK;
  assign sel       = reg_sel(paddr);

  genvar g;
  generate
    for (g = 0; g < 4; g++)
    begin : g_code
      if (g < CODE_CH)
      begin : g_used
        assign code_img[2*g+1:2*g] = diag_code(fault_ovl[g], fault_short[g], fault_open[g]);
      end
      else
      begin : g_zero
        assign code_img[2*g+1:2*g] = 2'h0;
      end
    end
  endgenerate

  always_comb
  begin
    case (DIAG_MODE)
      DIAG_FLAG: img_nxt = raw_fault;
      DIAG_CODE: img_nxt = code_img;
      default:   img_nxt = 8'h00;
    endcase
  end

  always_comb
  begin
    s_nxt        = s_r;
    s_nxt.flag   = raw_fault;
    s_nxt.in_img = img_nxt;
    // Set wins over a same-cycle write-one clear
    s_nxt.stat   = s_r.stat | s_r.flag;
    case (s_r.st)
      DODI_IDLE:
      begin
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (psel && penable)
        begin
          s_nxt.st      = DODI_ACK;
          s_nxt.pready  = 1'b1;
          s_nxt.pslverr = (sel == 3'h0);
          s_nxt.prdata  = 32'h0000_0000;
          if (!pwrite)
          begin
            case (sel)
              3'h1:    s_nxt.prdata = {24'h000000, s_r.out_img};
              3'h2:    s_nxt.prdata = {24'h000000, s_r.in_img};
              3'h3:    s_nxt.prdata = {24'h000000, s_r.stat};
              3'h4:    s_nxt.prdata = {24'h000000, s_r.mask};
              default: s_nxt.prdata = 32'h0000_0000;
            endcase
          end
        end
      end
      DODI_ACK:
      begin
        s_nxt.st      = DODI_IDLE;
        s_nxt.pready  = 1'b0;
        s_nxt.pslverr = 1'b0;
        if (pwrite)
        begin
          case (sel)
            3'h1:    s_nxt.out_img = pwdata[7:0] & CMASK;
            3'h3:    s_nxt.stat    = (s_r.stat & ~pwdata[7:0]) | s_r.flag;
            3'h4:    s_nxt.mask    = pwdata[7:0] & FMASK;
            default: s_nxt.stat    = s_r.stat | s_r.flag;
          endcase
        end
      end
      default:
      begin
        s_nxt.st     = DODI_IDLE;
        s_nxt.pready = 1'b0;
      end
    endcase
    s_nxt.irq = |(s_nxt.stat & s_nxt.mask);
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_r         <= '0;
      s_r.st      <= DODI_IDLE;
      s_r.out_img <= RST_OUT_IMG;
      s_r.mask    <= RST_IRQ_MASK;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign prdata   = s_r.prdata;
  assign pready   = s_r.pready;
  assign pslverr  = s_r.pslverr;
  assign do_out   = s_r.out_img;
  assign in_image = s_r.in_img;
  assign irq      = s_r.irq;

  // Checks

  a_flag_follows: assert property (@(posedge pclk) disable iff (!presetn)
    (DIAG_MODE != DIAG_NONE) |=> s_r.flag == ($past(fault_ovl | fault_short | fault_open) & CMASK))
    else $error("fault flag does not follow channel faults");

  a_flag_image: assert property (@(posedge pclk) disable iff (!presetn)
    (DIAG_MODE == DIAG_FLAG) |=> in_image == ($past(fault_ovl | fault_short | fault_open) & CMASK))
    else $error("flag image bits not in channel order");

  a_code_image: assert property (@(posedge pclk) disable iff (!presetn)
    (DIAG_MODE == DIAG_CODE && $past(fault_short[0])) |-> in_image[1:0] == CODE_SHORT)
    else $error("channel one code wrong on short circuit");

  a_in_unused_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (DIAG_MODE == DIAG_CODE) |-> (in_image >> (2 * CODE_CH)) == 8'h00)
    else $error("unused input image bits not zero");

  a_out_drive: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && paddr == OFF_OUT_IMG)
    |=> do_out == ($past(pwdata[7:0]) & CMASK))
    else $error("output byte not applied to channels");

  a_out_unused: assert property (@(posedge pclk) disable iff (!presetn)
    (do_out & ~CMASK) == 8'h00)
    else $error("unused output bit reached a channel");

  a_out_stable: assert property (@(posedge pclk) disable iff (!presetn)
    !(psel && penable && pready && pwrite) |=> $stable(do_out))
    else $error("output byte changed without a write");

  a_bus_answer: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready) |=> pready ##1 !pready)
    else $error("bus answer not one wait state");

  a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    s_r.flag != 8'h00 |=> (s_r.stat & $past(s_r.flag)) == $past(s_r.flag))
    else $error("fault status bit lost");

  a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
    ##1 irq == |(s_r.stat & s_r.mask))
    else $error("interrupt level disagrees with status");

  // Priority of the two-bit code: overload only when no short is present
  a_code_ovl: assert property (@(posedge pclk) disable iff (!presetn)
    (DIAG_MODE == DIAG_CODE && $past(fault_ovl[0] && !fault_short[0]))
    |-> in_image[1:0] == CODE_OVL)
    else $error("channel one code wrong on overload");

  a_code_open: assert property (@(posedge pclk) disable iff (!presetn)
    (DIAG_MODE == DIAG_CODE && $past(fault_open[0] && !fault_ovl[0] && !fault_short[0]))
    |-> in_image[1:0] == CODE_OPEN)
    else $error("channel one code wrong on broken wire");

  a_code_ok: assert property (@(posedge pclk) disable iff (!presetn)
    (DIAG_MODE == DIAG_CODE && $past(!fault_open[0] && !fault_ovl[0] && !fault_short[0]))
    |-> in_image[1:0] == CODE_OK)
    else $error("channel one code not clear without fault");

  a_none_zero: assert property (@(posedge pclk) disable iff (!presetn)
    (DIAG_MODE == DIAG_NONE) |-> (in_image == 8'h00 && !irq))
    else $error("variant without diagnostics shows fault data");

  a_mask_unused: assert property (@(posedge pclk) disable iff (!presetn)
    (s_r.mask & ~FMASK) == 8'h00)
    else $error("mask bit set for a missing channel");

  a_err_unmapped: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && !pready && sel == 3'h0) |=> (pslverr && prdata == 32'h0000_0000))
    else $error("unmapped access not refused");

  a_read_upper: assert property (@(posedge pclk) disable iff (!presetn)
    pready |-> prdata[31:8] == 24'h000000)
    else $error("upper read bits not zero");

  a_pready_pulse: assert property (@(posedge pclk) disable iff (!presetn)
    pready |=> !pready)
    else $error("bus answer longer than one cycle");

  // A clear only removes bits whose fault has gone
  a_stat_clear: assert property (@(posedge pclk) disable iff (!presetn)
    (psel && penable && pready && pwrite && paddr == OFF_IRQ_STAT)
    |=> (s_r.stat & $past(pwdata[7:0]) & ~$past(s_r.flag)) == 8'h00)
    else $error("status bit not cleared by write of one");

endmodule // dodi_top

/* bench/dodi_coupler.sv */
// Coupler-side model: APB master for the image registers, code decoder.
// Assumes one free running pclk and one slave answering at a time.
`timescale 1ns/1ps
module dodi_coupler (
  input  wire logic        pclk,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial {psel, penable, pwrite, paddr, pwdata} = '0;

  // Control goes out, diagnostics come back
  // Bounded wait: a lost answer leaves ok low for the caller
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] q, output logic err, output logic ok);
    int n;
    n = 0;
    ok = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    q = prdata;
    err = pslverr;
    ok = pready;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Two-bit code to {broken wire, short, overload}
  function automatic logic [2:0] decode(input logic [1:0] c);
    return {c == 2'h3, c == 2'h2, c == 2'h1};
  endfunction
endmodule // dodi_coupler

/* bench/tb_top.sv */
// Bench: an 8-channel flag block and a 2-channel code block on one APB.
// Assumes the coupler model steers the bus; sel_b picks the slave.
`timescale 1ns/1ps
module tb_top;
  import dodi_pkg::*;
  logic        pclk = 1'b0, presetn = 1'b0, sel_b = 1'b0, er, ok;
  logic [7:0]  fo = 8'h00, fs = 8'h00, fw = 8'h00, do_a, do_b, im_a, im_b;
  logic        psel, penable, pwrite, rdy_a, rdy_b, se_a, se_b, irq_a, irq_b;
  logic [11:0] paddr;
  logic [31:0] pwdata, rd_a, rd_b, q;
  int          n_errors = 0, num_checks = 0;
  // Overload, short, broken wire, flag image, code image
  logic [7:0]  rows [5][5] = '{'{8'h00, 8'h00, 8'h00, 8'h00, 8'h00},
    '{8'h01, 8'h00, 8'h00, 8'h01, 8'h01}, '{8'h00, 8'h02, 8'h00, 8'h02, 8'h08},
    '{8'h00, 8'h00, 8'hFF, 8'hFF, 8'h0F}, '{8'h03, 8'h01, 8'h80, 8'h83, 8'h06}};

  always #5 pclk = ~pclk;

  dodi_top #(.CHANNELS(8), .DIAG_MODE(1)) dodi_top_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel & ~sel_b), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(rd_a), .pready(rdy_a), .pslverr(se_a), .fault_ovl(fo),
    .fault_short(fs), .fault_open(fw), .do_out(do_a), .in_image(im_a), .irq(irq_a));
  dodi_top #(.CHANNELS(2), .DIAG_MODE(2)) dodi_top_b_inst (.pclk(pclk), .presetn(presetn),
    .psel(psel & sel_b), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(rd_b), .pready(rdy_b), .pslverr(se_b), .fault_ovl(fo),
    .fault_short(fs), .fault_open(fw), .do_out(do_b), .in_image(im_b), .irq(irq_b));
  dodi_coupler dodi_coupler_inst (.pclk(pclk), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(sel_b ? rd_b : rd_a),
    .pready(sel_b ? rdy_b : rdy_a), .pslverr(sel_b ? se_b : se_a));

  task automatic wrap_up;
    if (n_errors == 0 && num_checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    num_checks++;
    if (g !== e)
    begin
      n_errors++;
      $display("Error %0t: got %h want %h", $time, g, e);
    end
  endtask

  task automatic bus(input logic w, input logic [11:0] a, input logic [7:0] d);
    dodi_coupler_inst.xfer(w, a, {24'h000000, d}, q, er, ok);
    if (ok !== 1'b1)
    begin
      n_errors++;
      wrap_up();
    end
  endtask

  initial
  begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    chk(do_a, RST_OUT_IMG);
    chk(8'(irq_a), 8'h00);
    bus(1'b0, OFF_IRQ_MASK, 8'h00);
    chk(q[7:0], RST_IRQ_MASK);
    foreach (rows[i])
    begin
      fo <= rows[i][0];
      fs <= rows[i][1];
      fw <= rows[i][2];
      repeat (3) @(posedge pclk);
      chk(im_a, rows[i][3]);
      chk(im_b, rows[i][4]);
      chk(8'(irq_a), 8'h00);
      bus(1'b0, OFF_IN_IMG, 8'h00);
      chk(q[7:0], rows[i][3]);
    end
    chk(8'(dodi_coupler_inst.decode(im_b[1:0])), 8'h02);
    chk(8'(dodi_coupler_inst.decode(im_b[3:2])), 8'h01);
    fo <= 8'h00;
    fs <= 8'h00;
    fw <= 8'h00;
    bus(1'b1, OFF_IRQ_MASK, 8'h01);
    repeat (2) @(posedge pclk);
    chk(8'(irq_a), 8'h01);
    bus(1'b1, OFF_IRQ_STAT, 8'hFF);
    repeat (2) @(posedge pclk);
    chk(8'(irq_a), 8'h00);
    fo <= 8'h01;
    repeat (3) @(posedge pclk);
    // A fault still present wins over the clear
    bus(1'b1, OFF_IRQ_STAT, 8'h01);
    repeat (2) @(posedge pclk);
    chk(8'(irq_a), 8'h01);
    bus(1'b1, OFF_OUT_IMG, 8'hFF);
    bus(1'b1, OFF_OUT_IMG, 8'hA5);
    @(posedge pclk);
    chk(do_a, 8'hA5);
    bus(1'b1, OFF_IN_IMG, 8'hFF);
    chk(8'(er), 8'h00);
    bus(1'b0, 12'h010, 8'h00);
    chk(8'(er), 8'h01);
    chk(q[7:0], 8'h00);
    sel_b <= 1'b1;
    bus(1'b1, OFF_OUT_IMG, 8'hFF);
    @(posedge pclk);
    chk(do_b, 8'h03);
    bus(1'b0, OFF_OUT_IMG, 8'h00);
    chk(q[7:0], 8'h03);
    bus(1'b0, OFF_IN_IMG, 8'h00);
    chk(q[7:0], 8'h01);
    bus(1'b1, OFF_IRQ_MASK, 8'hFF);
    repeat (2) @(posedge pclk);
    chk(8'(irq_b), 8'h01);
    bus(1'b0, OFF_IRQ_MASK, 8'h00);
    chk(q[7:0], 8'h03);
    wrap_up();
  end
endmodule // tb_top
